// ### design/qmc_sync_regs.vh
// register indices, field positions and reset values of the sync-select bank
// included by the bank's design file only; definitions, no logic
`ifndef QMC_SYNC_REGS_VH
`define QMC_SYNC_REGS_VH

// register indices; byte address is four times the index
`define IDX_FACTORY_RESERVED_A 8'h1c
`define IDX_FACTORY_RESERVED_B 8'h1d
`define IDX_CORRECTION_SYNC_SELECT 8'h1e
`define IDX_SOFT_SYNC_CONTROL 8'h1f
`define IDX_SHADOW_BASE 8'h40
`define IDX_ACTIVE_BASE 8'h44

// reset values
`define RST_FACTORY_RESERVED 16'h0000
`define RST_CORRECTION_SYNC_SELECT 16'h1111
`define RST_SOFT_SYNC_CONTROL 16'h0000
`define RST_DOUBLE_BUFFERED 16'h0000

// field tops inside the sync-select register
`define FLD_AB_OFFSET_TOP 15
`define FLD_CD_OFFSET_TOP 11
`define FLD_AB_CORRECTION_TOP 7
`define FLD_CD_CORRECTION_TOP 3

// bit positions inside one four-bit source field
`define SRC_SOFT 3
`define SRC_SYNC 2
`define SRC_STROBE 1
`define SRC_AUTO 0

// software sync bit inside the soft sync control register
`define BIT_SOFT_SYNC 1

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### design/qmc_sync_source_select.v
// sync-source selection and double-buffered quadrature correction registers
// assumes one clock aclk, a synchronous low reset and an axi4-lite master;
// sync_input and output_strobe_input arrive synchronous to aclk
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "qmc_sync_regs.vh"

// Summary of operation
// [RULE1] bits 15:12 pick sync sources for the ab offset registers
// [RULE2] bits 11:8 pick sync sources for the cd offset registers
// [RULE3] bits 7:4 pick sync sources for the ab correction registers
// [RULE4] bits 3:0 pick sync sources for the cd correction registers
// [RULE5] a one enables its source; any enabled source triggers the transfer
// [RULE6] the sync-select register resets to 0x1111, auto sync only
// [RULE7] both factory reserved registers reset to zero and should stay there; the code still accepts writes that change them
// [RULE8] software writes the soft sync bit to one, then back to zero
// [RULE9] writes land in a shadow copy, moved to active on an enabled sync
module qmc_sync_source_select (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire awvalid,
    output wire awready,
    input wire [31:0] awaddr,
    input wire [2:0] awprot,
    // axi4-lite write data
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // axi4-lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // axi4-lite read address
    input wire arvalid,
    output wire arready,
    input wire [31:0] araddr,
    input wire [2:0] arprot,
    // axi4-lite read data
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // sync event inputs
    input wire sync_input,
    input wire output_strobe_input,
    // active copies: ab offset, cd offset, ab correction, cd correction
    output wire [63:0] active_values
);

    // captured write address and data, each taken on its own
    reg aw_held;
    reg w_held;
    reg [7:0] aw_index;
    reg aw_aligned;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    // registers
    reg [15:0] factory_reserved_a;
    reg [15:0] factory_reserved_b;
    reg [15:0] correction_sync_select;
    reg [15:0] soft_sync_control;
    reg soft_sync_prev;
    reg [15:0] shadow [0:3];
    reg [15:0] active [0:3];

    wire do_write;
    wire [15:0] merged_data;
    wire soft_sync_event;
    wire [3:0] group_write;
    wire write_hit;

    // a channel stalls once its half is held, until the response goes out
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;

    // only the low two byte lanes carry register bits
    assign merged_data = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};

    // soft sync acts on the rising edge of its bit, so a held one fires once
    assign soft_sync_event = soft_sync_control[`BIT_SOFT_SYNC] && !soft_sync_prev; // [RULE8]

    // write address decode
    assign write_hit = aw_aligned && ((aw_index >= `IDX_FACTORY_RESERVED_A &&
        aw_index <= `IDX_SOFT_SYNC_CONTROL) ||
        (aw_index >= `IDX_SHADOW_BASE && aw_index < `IDX_SHADOW_BASE + 8'h04));

    // address and data capture
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_index <= 8'h00;
            aw_aligned <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_index <= awaddr[9:2];
                aw_aligned <= (awaddr[1:0] == 2'h0) && (awaddr[31:10] == 22'h000000);
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // plain control registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            factory_reserved_a <= `RST_FACTORY_RESERVED; // [RULE7]
            factory_reserved_b <= `RST_FACTORY_RESERVED; // [RULE7]
            correction_sync_select <= `RST_CORRECTION_SYNC_SELECT; // [RULE6]
            soft_sync_control <= `RST_SOFT_SYNC_CONTROL;
            soft_sync_prev <= 1'b0;
        end else begin
            soft_sync_prev <= soft_sync_control[`BIT_SOFT_SYNC];
            if (do_write && aw_aligned) begin
                case (aw_index)
                    `IDX_FACTORY_RESERVED_A: factory_reserved_a <= merged_data;
                    `IDX_FACTORY_RESERVED_B: factory_reserved_b <= merged_data;
                    `IDX_CORRECTION_SYNC_SELECT: correction_sync_select <= merged_data;
                    `IDX_SOFT_SYNC_CONTROL: soft_sync_control <= merged_data;
                    default: soft_sync_control <= soft_sync_control;
                endcase
            end
        end
    end

    // one double-buffered group per field; group 0 uses bits 15:12
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : grp
            wire [3:0] sel;
            wire trigger;
            assign sel = correction_sync_select[15 - 4 * g -: 4]; // [RULE1] [RULE2] [RULE3] [RULE4]
            assign group_write[g] = do_write && aw_aligned &&
                (aw_index == `IDX_SHADOW_BASE + g);
            // any enabled source fires; several may be enabled at once
            assign trigger = (sel[`SRC_SOFT] && soft_sync_event) ||
                (sel[`SRC_SYNC] && sync_input) ||
                (sel[`SRC_STROBE] && output_strobe_input) ||
                (sel[`SRC_AUTO] && group_write[g]); // [RULE5]
            assign active_values[63 - 16 * g -: 16] = active[g];
            // auto sync takes the written word straight through, not the stale shadow
            always @(posedge aclk) begin
                if (!aresetn) begin
                    shadow[g] <= `RST_DOUBLE_BUFFERED;
                    active[g] <= `RST_DOUBLE_BUFFERED;
                end else begin
                    if (group_write[g]) begin
                        shadow[g] <= merged_data; // [RULE9]
                    end
                    if (trigger) begin
                        active[g] <= group_write[g] ? merged_data : shadow[g]; // [RULE9]
                    end
                end
            end
        end
    endgenerate

    // read channel; one cycle from the address to rvalid
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            rdata <= 32'h00000000;
            if (araddr[1:0] != 2'h0 || araddr[31:10] != 22'h000000) begin
                rresp <= `RESP_SLVERR;
            end else begin
                case (araddr[9:2])
                    `IDX_FACTORY_RESERVED_A: rdata <= {16'h0000, factory_reserved_a};
                    `IDX_FACTORY_RESERVED_B: rdata <= {16'h0000, factory_reserved_b};
                    `IDX_CORRECTION_SYNC_SELECT: rdata <= {16'h0000, correction_sync_select};
                    `IDX_SOFT_SYNC_CONTROL: rdata <= {16'h0000, soft_sync_control};
                    `IDX_SHADOW_BASE: rdata <= {16'h0000, shadow[0]};
                    `IDX_SHADOW_BASE + 8'h01: rdata <= {16'h0000, shadow[1]};
                    `IDX_SHADOW_BASE + 8'h02: rdata <= {16'h0000, shadow[2]};
                    `IDX_SHADOW_BASE + 8'h03: rdata <= {16'h0000, shadow[3]};
                    `IDX_ACTIVE_BASE: rdata <= {16'h0000, active[0]};
                    `IDX_ACTIVE_BASE + 8'h01: rdata <= {16'h0000, active[1]};
                    `IDX_ACTIVE_BASE + 8'h02: rdata <= {16'h0000, active[2]};
                    `IDX_ACTIVE_BASE + 8'h03: rdata <= {16'h0000, active[3]};
                    default: rresp <= `RESP_SLVERR;
                endcase
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

// ### verification/qmc_sync_source_select_monitor.sv
// assertions on the ports of the sync-select bank
// assumes one clock aclk and a synchronous active-low aresetn
`timescale 1ns/1ps
module qmc_sync_monitor (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // bus signals watched
    input logic awvalid,
    input logic [31:0] awaddr,
    input logic bvalid,
    input logic arvalid,
    input logic arready,
    input logic [31:0] araddr,
    input logic [31:0] rdata,
    // sync events and active copies
    input logic sync_input,
    input logic output_strobe_input,
    input logic [63:0] active_values
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic sel_touched;
    wire rd_take = arvalid && arready;
    // any offer to the select register counts, so the reset check stays conservative
    always_ff @(posedge aclk) sel_touched <= aresetn && (sel_touched || awvalid && awaddr == 32'h78);
    sel_reset_a: assert property (rd_take && araddr == 32'h78 && !sel_touched |=>
        rdata == 32'h1111) else $error("select register not at reset value");
    reserved_zero_a: assert property (rd_take && (araddr == 32'h70 || araddr == 32'h74) |=>
        rdata == 32'h0) else $error("reserved register not zero");
    ab_offset_a: assert property (rd_take && araddr == 32'h110 |=>
        rdata[15:0] == $past(active_values[63:48])) else $error("ab offset readback");
    cd_offset_a: assert property (rd_take && araddr == 32'h114 |=>
        rdata[15:0] == $past(active_values[47:32])) else $error("cd offset readback");
    ab_correction_a: assert property (rd_take && araddr == 32'h118 |=>
        rdata[15:0] == $past(active_values[31:16])) else $error("ab correction readback");
    cd_correction_a: assert property (rd_take && araddr == 32'h11c |=>
        rdata[15:0] == $past(active_values[15:0])) else $error("cd correction readback");
    active_hold_a: assert property ($changed(active_values) |-> $past(sync_input) ||
        $past(output_strobe_input) || bvalid || $past(bvalid)) else $error("active moved alone");
    // an update at one edge shows as a change at the next, so the first edge must be event free and bvalid low at both
    no_event_a: assert property (!sync_input && !output_strobe_input && !bvalid ##1
        !bvalid |-> $stable(active_values)) else $error("active moved with no event");
endmodule
bind qmc_sync_source_select qmc_sync_monitor mon (.aclk, .aresetn, .awvalid, .awaddr, .bvalid,
    .arvalid, .arready, .araddr, .rdata, .sync_input, .output_strobe_input, .active_values);

// ### verification/tb_qmc_sync_source_select.sv
// self-checking bench for the sync-select bank with a model of shadow and active copies
// drives the axi4-lite ports and both sync inputs directly
`timescale 1ns/1ps
module tb_qmc_sync_source_select;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic sync_input = 0, output_strobe_input = 0, awready, wready, arready, bvalid, rvalid;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic [1:0] bresp, rresp, br;
    logic [63:0] active_values;
    logic [15:0] shd [4], act [4], sel;
    logic [33:0] rv;
    int fails = 0, n_tests = 0, cyc = 0;
    // 20 MHz clock
    always #25 aclk = ~aclk;
    qmc_sync_source_select DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
        .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .sync_input,
        .output_strobe_input, .active_values);
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // both halves offered together, each dropped once taken; bready held until the answer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= a;
        wdata <= d;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        br = bresp;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge aclk);
        {arvalid, rready} <= 2'h3;
        araddr <= a;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        rv = {rresp, rdata};
    endtask
    // shadow write; the model moves it on at once only when auto sync is enabled
    task automatic wrs(input int g, input logic [15:0] v);
        wr(32'h100 + 4 * g, {16'h0, v});
        shd[g] = v;
        if (sel[12 - 4 * g]) act[g] = v;
    endtask
    // raise one source: 3 soft, 2 sync input, 1 output strobe, 0 none
    task automatic fire(input int s);
        if (s == 3) begin
            wr(32'h7c, 32'h2);
            wr(32'h7c, 32'h0);
        end else if (s > 0) begin
            @(posedge aclk);
            {sync_input, output_strobe_input} <= (s == 2) ? 2'b10 : 2'b01;
            @(posedge aclk);
            {sync_input, output_strobe_input} <= 2'b00;
        end
        if (s > 0) for (int h = 0; h < 4; h++) if (sel[12 - 4 * h + s]) act[h] = shd[h];
        repeat (2) @(posedge aclk);
        chk("active_values", {act[0], act[1], act[2], act[3]}, active_values);
    endtask
    // hang guard, far above the expected run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_of_test;
        end
    end
    initial begin
        void'($urandom(32'h114e3f83));
        sel = 16'h1111;
        shd = '{default: 16'h0};
        act = '{default: 16'h0};
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        rd(32'h70);
        chk("reserved_a", 34'h0, rv);
        rd(32'h74);
        chk("reserved_b", 34'h0, rv);
        rd(32'h78);
        chk("select", 34'h1111, rv);
        rd(32'h3f0);
        chk("unmapped read", 34'h2_0000_0000, rv);
        wr(32'h110, 32'h1234);
        chk("active write", 2'h2, br);
        $display("test reset and map done");
        for (int g = 0; g < 4; g++) wrs(g, 16'($urandom));
        fire(0);
        $display("test auto sync done");
        // one source bit of one field at a time
        for (int g = 0; g < 4; g++) for (int s = 0; s < 4; s++) begin
            sel = 16'h1 << (12 - 4 * g + s);
            wr(32'h78, {16'h0, sel});
            wrs(g, 16'($urandom));
            chk("before sync", {act[0], act[1], act[2], act[3]}, active_values);
            fire(s);
            rd(32'h110 + 4 * g);
            chk("active readback", {18'h0, act[g]}, rv);
        end
        $display("test single sources done");
        sel = 16'h6666;
        wr(32'h78, {16'h0, sel});
        for (int g = 0; g < 4; g++) wrs(g, 16'($urandom));
        fire(1);
        for (int g = 0; g < 4; g++) wrs(g, 16'($urandom));
        fire(2);
        $display("test multiple sources done");
        end_of_test;
    end
endmodule
